//--- logic/eac_consts.svh
`ifndef EAC_CONSTS_SVH
`define EAC_CONSTS_SVH

// register indices; byte address is four times the index
`define EAC_IDX_DATA 10'h09a
`define EAC_IDX_ADDR 10'h09b
`define EAC_IDX_CTRL 10'h09c
`define EAC_IDX_UNLOCK 10'h09d
`define EAC_IDX_STATUS 10'h0a0
`define EAC_IDX_MASK 10'h0a1

// control register fields
`define EAC_BIT_RD 0
`define EAC_BIT_WR 1
`define EAC_BIT_ALLOW 2
`define EAC_BIT_ABORTED 3

// interrupt status and mask fields
`define EAC_ST_DONE 0
`define EAC_ST_ABORT 1
`define EAC_ST_W 2

// unlock keys
`define EAC_KEY_FIRST 8'h55
`define EAC_KEY_SECOND 8'haa

// timing
`define EAC_CLK_MHZ 50
`define EAC_WRITE_TIME_US 100
`define EAC_UNLOCK_GAP 4'h8

// reset values
`define EAC_BYTE_RST 8'h00
`define EAC_WORD_RST 32'h0000_0000

`endif

//--- logic/eac_pkg.sv
package eac_pkg;

  typedef enum logic [1:0] {
    eac_unl_idle = 2'b00,
    eac_unl_key1 = 2'b01,
    eac_unl_armed = 2'b11
  } eac_unlock_t;

endpackage : eac_pkg

//--- logic/eac_wr_timer.sv
`include "eac_consts.svh"

module eac_wr_timer #(
  parameter int CYCLES = 5000
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);

  logic [23:0] cnt_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 24'h00_0000;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
        cnt_q <= 24'h00_0000;
      end else if (start && !busy) begin
        busy <= 1'b1;
        cnt_q <= 24'(CYCLES - 1);
      end else if (busy) begin
        if (cnt_q == 24'h00_0000) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 24'h00_0001;
        end
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_TMR_START: assert property (start && !busy && !abort |=> busy)
    else $error("write timer did not start");
  AST_TMR_ABORT: assert property (abort |=> !busy && !done)
    else $error("write timer survived an abort");

endmodule // eac_wr_timer

//--- logic/eac_top.sv
// Behaviour
// - only low four control bits exist; upper four ignore writes, read zero.
// - software can only set read and write triggers; writing zero does nothing.
// - hardware clears each trigger when its operation finishes.
// - write-allow one permits writes; zero inhibits starting any array write.
// - write-allow is zero after power-up.
// - aborted-write flag sets when a write is cut by external resets.
// - aborted-write flag zero means write completed; software may clear it.
// - a reset clears data and address registers; software reloads both.
// - write-complete flag sets at write end; only software clears it.
// - unlock key port stores nothing and reads as zero.
// - unlock key port only receives the write-initiation keys.
// - read trigger completes in one cycle, then clears itself.
// - write trigger starts a write; reading zero means no write pending.
// - write starts only after 55h, AAh to key port, then trigger.
// - setting write trigger is ignored while write-allow is zero.
// - clearing write-allow mid-write has no effect; in hardware only outside resets clear it.
// - read byte lands in data register next cycle and stays there.
`include "eac_consts.svh"

module eac_top #(
  parameter int WRITE_CYCLES = `EAC_WRITE_TIME_US * `EAC_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic master_clear_reset,
  input wire logic watchdog_unit_reset,
  input wire logic brownout_detect,
  output logic irq
);

  logic [9:0] idx;
  logic apb_setup;
  logic apb_fire;
  logic wr_acc;
  logic soft_rst;
  logic mapped;
  logic ctrl_wr;
  logic key_wr;
  logic start_wr;
  logic tmr_busy;
  logic tmr_done;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic irq_q;
  logic rd_q;
  logic wr_q;
  logic write_allow_q;
  logic aborted_q;
  logic [7:0] data_q;
  logic [7:0] addr_q;
  logic [7:0] mem [256];
  logic [`EAC_ST_W-1:0] st_q;
  logic [`EAC_ST_W-1:0] st_set;
  logic [`EAC_ST_W-1:0] mask_q;
  logic [3:0] gap_q;
  eac_pkg::eac_unlock_t unl_q;
  eac_pkg::eac_unlock_t unl_d;

  assign idx = paddr[11:2];
  assign apb_setup = psel && !penable;
  assign apb_fire = psel && penable && pready_q;
  assign wr_acc = apb_fire && pwrite && pstrb[0];
  // any of the three outside resets aborts the block synchronously
  assign soft_rst = master_clear_reset || watchdog_unit_reset || brownout_detect;
  assign ctrl_wr = wr_acc && (idx == `EAC_IDX_CTRL);
  assign key_wr = wr_acc && (idx == `EAC_IDX_UNLOCK);
  assign mapped = (idx == `EAC_IDX_DATA) || (idx == `EAC_IDX_ADDR) || (idx == `EAC_IDX_CTRL) ||
                  (idx == `EAC_IDX_UNLOCK) || (idx == `EAC_IDX_STATUS) || (idx == `EAC_IDX_MASK);

  // stored allow is checked, so allow set by the trigger's own write does not count
  assign start_wr = ctrl_wr && pwdata[`EAC_BIT_WR] && !wr_q && !soft_rst
                    && write_allow_q
                    && (unl_q == eac_pkg::eac_unl_armed);

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  eac_wr_timer #(
    .CYCLES(WRITE_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(start_wr),
    .abort(soft_rst),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // no wait state: ready rises in the access phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup && !mapped;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= `EAC_WORD_RST;
    end else if (apb_setup && !pwrite) begin
      case (idx)
        `EAC_IDX_DATA: prdata_q <= {24'h00_0000, data_q};
        `EAC_IDX_ADDR: prdata_q <= {24'h00_0000, addr_q};
        `EAC_IDX_CTRL: prdata_q <= {28'h000_0000, aborted_q, write_allow_q, wr_q, rd_q};
        `EAC_IDX_UNLOCK: prdata_q <= `EAC_WORD_RST;
        `EAC_IDX_STATUS: prdata_q <= {30'h0000_0000, st_q};
        `EAC_IDX_MASK: prdata_q <= {30'h0000_0000, mask_q};
        default: prdata_q <= `EAC_WORD_RST;
      endcase
    end else begin
      prdata_q <= `EAC_WORD_RST;
    end
  end

  // read trigger: set-only from software, one cycle long
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
    end else if (soft_rst || rd_q) begin
      rd_q <= 1'b0;
    end else if (ctrl_wr && pwdata[`EAC_BIT_RD]) begin
      rd_q <= 1'b1;
    end
  end

  // write trigger follows the timer; software zero is ignored
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
    end else if (soft_rst || tmr_done) begin
      wr_q <= 1'b0;
    end else if (start_wr) begin
      wr_q <= 1'b1;
    end
  end

  // outside resets also clear the allow bit, but no write end ever does
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_allow_q <= 1'b0;
    end else if (soft_rst) begin
      write_allow_q <= 1'b0;
    end else if (ctrl_wr) begin
      write_allow_q <= pwdata[`EAC_BIT_ALLOW];
    end
  end

  // hardware set wins over a software write in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aborted_q <= 1'b0;
    end else if (soft_rst && wr_q) begin
      aborted_q <= 1'b1;
    end else if (ctrl_wr) begin
      aborted_q <= pwdata[`EAC_BIT_ABORTED];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= `EAC_BYTE_RST;
    end else if (soft_rst) begin
      addr_q <= `EAC_BYTE_RST;
    end else if (wr_acc && (idx == `EAC_IDX_ADDR)) begin
      addr_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= `EAC_BYTE_RST;
    end else if (soft_rst) begin
      data_q <= `EAC_BYTE_RST;
    end else if (rd_q) begin
      data_q <= mem[addr_q];
    end else if (wr_acc && (idx == `EAC_IDX_DATA)) begin
      data_q <= pwdata[7:0];
    end
  end

  // array has no reset; the byte is committed at the timer's end, using
  // data and address as they stand then, which software leaves untouched
  always_ff @(posedge core_clk) begin
    if (tmr_done && wr_q && !soft_rst) begin
      mem[addr_q] <= data_q;
    end
  end

  // unlock sequence: any other access or a long pause disarms it
  always_comb begin
    unl_d = unl_q;
    if (apb_fire) begin
      unl_d = eac_pkg::eac_unl_idle;
      if (key_wr && (pwdata[7:0] == `EAC_KEY_FIRST) && (unl_q == eac_pkg::eac_unl_idle)) begin
        unl_d = eac_pkg::eac_unl_key1;
      end else if (key_wr && (pwdata[7:0] == `EAC_KEY_SECOND) && (unl_q == eac_pkg::eac_unl_key1)) begin
        unl_d = eac_pkg::eac_unl_armed;
      end
    end else if (gap_q == `EAC_UNLOCK_GAP) begin
      unl_d = eac_pkg::eac_unl_idle;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unl_q <= eac_pkg::eac_unl_idle;
    end else if (soft_rst) begin
      unl_q <= eac_pkg::eac_unl_idle;
    end else begin
      case (unl_q)
        eac_pkg::eac_unl_idle: unl_q <= unl_d;
        eac_pkg::eac_unl_key1: unl_q <= unl_d;
        eac_pkg::eac_unl_armed: unl_q <= unl_d;
        default: unl_q <= eac_pkg::eac_unl_idle;
      endcase
    end
  end

  // cycles since the last unlock step
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 4'h0;
    end else if (apb_fire || (unl_q == eac_pkg::eac_unl_idle)) begin
      gap_q <= 4'h0;
    end else if (gap_q != `EAC_UNLOCK_GAP) begin
      gap_q <= gap_q + 4'h1;
    end
  end

  // sticky events, write one to clear, set wins
  always_comb begin
    st_set = '0;
    st_set[`EAC_ST_DONE] = tmr_done && !soft_rst;
    st_set[`EAC_ST_ABORT] = soft_rst && wr_q;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (wr_acc && (idx == `EAC_IDX_STATUS)) begin
      st_q <= (st_q & ~pwdata[`EAC_ST_W-1:0]) | st_set;
    end else begin
      st_q <= st_q | st_set;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= '0;
    end else if (wr_acc && (idx == `EAC_IDX_MASK)) begin
      mask_q <= pwdata[`EAC_ST_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(st_q & mask_q);
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_UPPER_ZERO: assert property (apb_setup && !pwrite && idx == `EAC_IDX_CTRL
    |=> prdata_q[31:4] == 28'h000_0000)
    else $error("control upper bits not zero");
  AST_NO_SW_CLEAR: assert property (wr_q && !tmr_done && !soft_rst |=> wr_q)
    else $error("write trigger dropped early");
  AST_WR_CLEARS: assert property (tmr_done |=> !wr_q && !tmr_busy)
    else $error("write trigger not cleared at write end");
  AST_NEEDS_ALLOW: assert property ($rose(wr_q) |-> $past(write_allow_q))
    else $error("write began without write-allow");
  AST_ALLOW_RESET: assert property (soft_rst |=> !write_allow_q)
    else $error("write-allow survived reset");
  AST_ABORT_FLAG: assert property (soft_rst && wr_q |=> aborted_q && !wr_q && st_q[`EAC_ST_ABORT])
    else $error("aborted write not flagged");
  AST_CLEAR_REGS: assert property (soft_rst |=> data_q == 8'h00 && addr_q == 8'h00)
    else $error("data or address not cleared");
  AST_DONE_FLAG: assert property (tmr_done && !soft_rst |=> st_q[`EAC_ST_DONE])
    else $error("write-complete flag not set");
  AST_DONE_STICKY: assert property (st_q[`EAC_ST_DONE] && !wr_acc |=> st_q[`EAC_ST_DONE])
    else $error("write-complete flag lost");
  AST_KEY_READ: assert property (apb_setup && idx == `EAC_IDX_UNLOCK |=> prdata_q == 32'h0000_0000)
    else $error("key port read not zero");
  AST_RD_ONE: assert property (rd_q |=> !rd_q)
    else $error("read trigger longer than one cycle");
  AST_RD_DATA: assert property (rd_q && !soft_rst |=> data_q == $past(mem[addr_q]))
    else $error("read byte not loaded");
  AST_SEQ: assert property ($rose(wr_q) |-> $past(unl_q) == eac_pkg::eac_unl_armed)
    else $error("write began without unlock");
  AST_TIMED: assert property (wr_q |-> tmr_busy || tmr_done)
    else $error("write trigger without timer");

  // trigger, allow and aborted-flag bookkeeping
  AST_RD_START: assert property (ctrl_wr && pwdata[`EAC_BIT_RD] && !rd_q && !soft_rst |=> rd_q)
    else $error("read trigger not set");
  AST_WR_START: assert property (start_wr |=> wr_q && tmr_busy)
    else $error("accepted write did not start");
  AST_NO_ALLOW: assert property (!write_allow_q && !wr_q |=> !wr_q)
    else $error("write trigger set without write-allow");
  AST_ALLOW_HELD: assert property (write_allow_q && !soft_rst && !ctrl_wr |=> write_allow_q)
    else $error("write-allow cleared by hardware");
  AST_ALLOW_NO_EFFECT: assert property (wr_q && !tmr_done && !soft_rst && ctrl_wr
    && !pwdata[`EAC_BIT_ALLOW] |=> wr_q)
    else $error("clearing write-allow cut a write");
  AST_ABORT_HELD: assert property (aborted_q && !ctrl_wr |=> aborted_q)
    else $error("aborted-write flag lost");
  AST_ABORT_CLEAR: assert property (ctrl_wr && !pwdata[`EAC_BIT_ABORTED]
    && !(soft_rst && wr_q) |=> !aborted_q)
    else $error("aborted-write flag not cleared by software");
  AST_DONE_IN_WRITE: assert property (tmr_done |-> wr_q)
    else $error("write end without a write");
  AST_DONE_PULSE: assert property (tmr_done |=> !tmr_done)
    else $error("write end longer than one cycle");

  // unlock sequence, read path and interrupt
  AST_KEY_ONE: assert property (key_wr && !soft_rst && unl_q == eac_pkg::eac_unl_idle
    && pwdata[7:0] == `EAC_KEY_FIRST |=> unl_q == eac_pkg::eac_unl_key1)
    else $error("first key not taken");
  AST_KEY_TWO: assert property (key_wr && !soft_rst && unl_q == eac_pkg::eac_unl_key1
    && pwdata[7:0] == `EAC_KEY_SECOND |=> unl_q == eac_pkg::eac_unl_armed)
    else $error("second key not taken");
  AST_KEY_INERT: assert property (key_wr && !soft_rst
    |=> $stable(write_allow_q) && $stable(aborted_q) && $stable(addr_q) && $stable(mask_q))
    else $error("key write changed a register");
  AST_GAP_DISARM: assert property (gap_q == `EAC_UNLOCK_GAP && !apb_fire
    |=> unl_q == eac_pkg::eac_unl_idle)
    else $error("unlock survived a long pause");
  AST_DATA_KEPT: assert property (!rd_q && !soft_rst && !(wr_acc && idx == `EAC_IDX_DATA) |=> $stable(data_q))
    else $error("data register changed without cause");
  AST_IRQ_LEVEL: assert property (|(st_q & mask_q) |=> irq_q)
    else $error("interrupt missing");
  AST_IRQ_QUIET: assert property (!(|(st_q & mask_q)) |=> !irq_q)
    else $error("interrupt without cause");

endmodule // eac_top

//--- tb/eeprom_access_control_bench.sv
`include "eac_consts.svh"

module eeprom_access_control_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // short write time keeps the run brief; the write-duration window check derives from it
  localparam int WC = 20;
  localparam logic [11:0] A_DATA = {`EAC_IDX_DATA, 2'b00};
  localparam logic [11:0] A_ADDR = {`EAC_IDX_ADDR, 2'b00};
  localparam logic [11:0] A_CTRL = {`EAC_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_UNL = {`EAC_IDX_UNLOCK, 2'b00};
  localparam logic [11:0] A_STAT = {`EAC_IDX_STATUS, 2'b00};
  localparam logic [11:0] A_MASK = {`EAC_IDX_MASK, 2'b00};

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic [2:0] ext_rst = 3'h0;
  logic irq;
  logic [31:0] rv;
  logic re;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int t0;

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  eac_top #(.WRITE_CYCLES(WC)) i_dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .master_clear_reset(ext_rst[0]),
    .watchdog_unit_reset(ext_rst[1]),
    .brownout_detect(ext_rst[2]),
    .irq(irq)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one transfer, then one idle edge so back-to-back calls never double-drive psel
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fail_count++;
      test_done;
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0, 4'hf);
  endtask

  task automatic start_wr(input logic [7:0] k1, input logic [7:0] k2);
    wr(A_CTRL, 32'h4);
    wr(A_UNL, {24'h0, k1});
    wr(A_UNL, {24'h0, k2});
    wr(A_CTRL, 32'h6);
  endtask

  task automatic t_reset;
    rd(A_CTRL);
    check(rv, 32'h0);
    rd(A_DATA);
    check(rv, 32'h0);
    rd(A_STAT);
    check(rv, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask

  task automatic t_regs;
    wr(A_CTRL, 32'h0000_00f0);
    rd(A_CTRL);
    check(rv, 32'h0);
    wr(A_UNL, 32'h5a);
    rd(A_UNL);
    check(rv, 32'h0);
    rd(A_CTRL);
    check(rv, 32'h0);
    rd(12'h300);
    check({31'h0, re}, 32'h1);
    check(rv, 32'h0);
    apb(1'b1, A_ADDR, 32'h77, 4'h0);
    rd(A_ADDR);
    check(rv, 32'h0);
  endtask

  // wrong key order, missing key and missing write-allow must all leave wr clear
  task automatic t_locked;
    wr(A_UNL, 32'h55);
    wr(A_UNL, 32'haa);
    wr(A_CTRL, 32'h2);
    rd(A_CTRL);
    check(rv, 32'h0);
    start_wr(8'haa, 8'h55);
    rd(A_CTRL);
    check(rv, 32'h4);
    start_wr(8'h55, 8'h00);
    rd(A_CTRL);
    check(rv, 32'h4);
    // keys right, but the pause before the trigger is too long
    wr(A_UNL, 32'h55);
    wr(A_UNL, 32'haa);
    repeat (10) @(posedge core_clk);
    wr(A_CTRL, 32'h6);
    rd(A_CTRL);
    check(rv, 32'h4);
    rd(A_STAT);
    check(rv, 32'h0);
  endtask

  task automatic t_write;
    int n;
    wr(A_ADDR, 32'h12);
    wr(A_DATA, 32'h3c);
    start_wr(8'h55, 8'haa);
    t0 = cyc;
    rd(A_CTRL);
    check(rv, 32'h6);
    wr(A_CTRL, 32'h0);
    rd(A_CTRL);
    check(rv, 32'h2);
    n = 0;
    do begin
      rd(A_CTRL); // data, address and control left alone while polling
      n++;
    end while (rv[1] !== 1'b0 && n < 40);
    check({31'h0, (cyc - t0 >= WC) && (cyc - t0 <= WC + 8)}, 32'h1);
    check(rv, 32'h0);
    rd(A_STAT);
    check(rv, 32'h1);
    check({31'h0, irq}, 32'h0);
    wr(A_MASK, 32'h1);
    @(posedge core_clk);
    check({31'h0, irq}, 32'h1);
    rd(A_STAT);
    check(rv, 32'h1);
    wr(A_STAT, 32'h1);
    @(posedge core_clk);
    check({31'h0, irq}, 32'h0);
    wr(A_MASK, 32'h0);
  endtask

  task automatic t_read;
    wr(A_DATA, 32'h0);
    wr(A_ADDR, 32'h12);
    wr(A_CTRL, 32'h1);
    rd(A_CTRL);
    check(rv, 32'h0);
    rd(A_DATA);
    check(rv, 32'h3c);
    rd(A_DATA);
    check(rv, 32'h3c);
  endtask

  // each outside reset source cuts a write in progress
  task automatic t_abort;
    for (int i = 0; i < 3; i++) begin
      wr(A_ADDR, 32'h21);
      wr(A_DATA, 32'h05);
      start_wr(8'h55, 8'haa);
      repeat (3) @(posedge core_clk);
      ext_rst <= 3'h1 << i;
      @(posedge core_clk);
      ext_rst <= 3'h0;
      @(posedge core_clk);
      rd(A_CTRL);
      check(rv, 32'h8);
      rd(A_DATA);
      check(rv, 32'h0);
      rd(A_ADDR);
      check(rv, 32'h0);
      rd(A_STAT);
      check(rv, 32'h2);
      wr(A_STAT, 32'h3);
      wr(A_CTRL, 32'h0);
      rd(A_CTRL);
      check(rv, 32'h0);
    end
  endtask

  // power-on reset in mid-run drops write-allow again
  task automatic t_power;
    wr(A_CTRL, 32'h4);
    rd(A_CTRL);
    check(rv, 32'h4);
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(A_CTRL);
    check(rv, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_reset;
    t_regs;
    t_locked;
    t_write;
    t_read;
    t_abort;
    t_power;
    test_done;
  end

endmodule // eeprom_access_control_bench
